// ==== hdl/sppr_params.svh ====
// constants for the stream packet pacer and resend pool
// assumes a 40 MHz core clock and the 8 ns stream tick
`ifndef SPPR_PARAMS_SVH
`define SPPR_PARAMS_SVH
`define SPPR_CLK_MHZ          40'h28
`define SPPR_CLK_PERIOD_NS    (40'h3e8 / `SPPR_CLK_MHZ)
`define SPPR_TICK_NS          40'h8
`define SPPR_TICK_FREQ_HZ     32'h07735940
`define SPPR_LT_TOTAL_BYTES   16'h24
`define SPPR_LT_PACKET_BYTES  16'h12
`define SPPR_PCT_FULL         80'h64
`define SPPR_STREAM_CHANNEL   8'h00
`define SPPR_RST_PACKET_SIZE  16'h05dc
`define SPPR_RST_GAP          16'h0000
`define SPPR_RST_DELAY        32'h00000000
`define SPPR_RST_PCT          8'h0a
`define SPPR_RST_MULT         8'h02
`endif

// ==== hdl/sppr_pkg.sv ====
// types for the stream packet pacer and resend pool
// assumes sppr_params.svh supplies the numeric constants
package sppr_pkg;
  typedef enum logic [1:0] {
    SPPR_LEADER  = 2'b00,
    SPPR_PAYLOAD = 2'b01,
    SPPR_TRAILER = 2'b10
  } sppr_kind_t;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_DELAY = 2'b01,
    TX_EMIT  = 2'b10,
    TX_HOLD  = 2'b11
  } sppr_tx_t;
  typedef enum logic [1:0] {
    CALC_IDLE  = 2'b00,
    CALC_COUNT = 2'b01,
    CALC_RATE  = 2'b10,
    CALC_RESV  = 2'b11
  } sppr_calc_t;
  typedef struct packed {
    logic [15:0] packet_size;
    logic [15:0] gap;
    logic [31:0] delay;
    logic [7:0]  pct;
    logic [7:0]  mult;
  } sppr_cfg_t;
  typedef struct packed {
    sppr_kind_t  kind;
    logic [15:0] bytes;
  } sppr_pkt_t;
endpackage

// ==== hdl/sppr_div.sv ====
// sequential restoring divider, one quotient bit per clock
// assumes start only while idle; a zero divisor gives zero
`timescale 1ns/1ps
module sppr_div #(
  parameter int W = 80
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  output logic              done,
  output logic [W-1:0]      quo
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0]  rem;
  logic [W-1:0]  q;
  logic [W-1:0]  d;
  logic [CW-1:0] cnt;
  logic          busy;
  wire  [W:0]    trial = {rem, q[W-1]} - {1'b0, d};

  assign quo = (d == '0) ? '0 : q;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt  <= '0;
      rem  <= '0;
      q    <= '0;
      d    <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        cnt  <= CW'(W);
        rem  <= '0;
        q    <= num;
        d    <= den;
      end else if (busy) begin
        if (trial[W]) begin
          rem <= {rem[W-2:0], q[W-1]};
          q   <= {q[W-2:0], 1'b0};
        end else begin
          rem <= trial[W-1:0];
          q   <= {q[W-2:0], 1'b1};
        end
        cnt <= cnt - 1'b1;
        if (cnt == CW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== hdl/sppr_top.sv ====
// stream packet pacer: block framing, gap and delay pacing, bandwidth and resend pool
// assumes all inputs come from logic on CLK; config written by CFG_WRITE strobe
// How it works
// - payload size is image plus enabled chunk bytes
// - only stream channel zero accepts settings
// - packet size sets payloads; leader/trailer fixed
// - full payload carries packet size minus 36
// - gap ticks times 8 ns between packets
// - readable tick frequency in ticks per second
// - frame start delayed by programmed delay ticks
// - report assigned bandwidth in bytes per second
// - one tick per transmitted byte assumed
// - reserve percentage sets resends per frame
// - pool capped at multiplier times frame reserve
// - pool starts full after initialization
// - unused reserve credits pool; overflow debits pool
// - refuse resend when reserve and pool empty
`timescale 1ns/1ps
`include "sppr_params.svh"
module sppr_top (
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic                CFG_WRITE,
  input  wire logic [7:0]          CHANNEL_SEL,
  input  wire logic [15:0]         PACKET_SIZE,
  input  wire logic [15:0]         INTER_PACKET_GAP_TICKS,
  input  wire logic [31:0]         FRAME_DELAY_TICKS,
  input  wire logic [7:0]          RESERVE_PCT,
  input  wire logic [7:0]          ACCUM_MULT,
  input  wire logic [31:0]         IMAGE_BYTES,
  input  wire logic [31:0]         CHUNK_BYTES,
  input  wire logic                CHUNK_EN,
  input  wire logic                FRAME_START,
  input  wire logic                RESEND_REQ,
  output logic                     PKT_START,
  output sppr_pkg::sppr_pkt_t      PKT_INFO,
  output logic                     TX_BUSY,
  output logic                     CHANNEL_ERR,
  output logic [31:0]              PAYLOAD_SIZE,
  output logic [31:0]              TICK_FREQ,
  output logic [31:0]              BANDWIDTH,
  output logic [23:0]              RESERVE_LEFT,
  output logic [31:0]              POOL_LEVEL,
  output logic [31:0]              POOL_CAP,
  output logic                     RESEND_GRANT,
  output logic                     RESEND_REFUSE
);
  function automatic logic [15:0] data_of(input logic [15:0] ps);
    data_of = (ps > `SPPR_LT_TOTAL_BYTES) ? ps - `SPPR_LT_TOTAL_BYTES : 16'h0001;
  endfunction
  function automatic logic [39:0] to_ns(input logic [32:0] ticks);
    to_ns = 40'(ticks) * `SPPR_TICK_NS;
  endfunction

  sppr_pkg::sppr_cfg_t  cfg;
  sppr_pkg::sppr_tx_t   tx_state;
  sppr_pkg::sppr_calc_t calc_state;
  sppr_pkg::sppr_kind_t kind;
  logic [39:0] ns_acc;
  logic [39:0] wait_ns;
  logic [31:0] rem;
  logic [15:0] data_sz;
  logic [15:0] tx_gap;
  logic        last;
  logic [79:0] snap;
  logic        launch;
  logic        div_start;
  logic        calc_done;
  logic        primed;
  logic        warm;
  logic [31:0] pkts;
  logic [23:0] reserve_per_frame;
  logic        div_done;
  logic [79:0] div_q;
  logic [23:0] next_res;
  logic [31:0] next_pool;
  logic        next_grant;
  logic        next_refuse;

  // configuration and derived values
  wire        cfg_ok      = CFG_WRITE && (CHANNEL_SEL == `SPPR_STREAM_CHANNEL);
  wire [31:0] next_payload = IMAGE_BYTES + (CHUNK_EN ? CHUNK_BYTES : 32'h0);
  wire [79:0] calc_key    = {PAYLOAD_SIZE, cfg.packet_size, cfg.gap, cfg.pct, cfg.mult};
  wire [31:0] snap_pay    = snap[79:48];
  wire [15:0] snap_ps     = snap[47:32];
  wire [15:0] snap_gap    = snap[31:16];
  wire [7:0]  snap_pct    = snap[15:8];
  wire [7:0]  snap_mult   = snap[7:0];
  wire [47:0] xy          = 48'(pkts) * 48'(snap_ps);
  wire [31:0] pkts_m1     = pkts - 32'h1;
  wire [79:0] count_num   = 80'(snap_pay) + 80'(data_of(snap_ps)) - 80'h1;
  wire [79:0] rate_num    = 80'(xy) * 80'(`SPPR_TICK_FREQ_HZ);
  wire [79:0] rate_den    = 80'(xy) + 80'(pkts_m1) * 80'(snap_gap);
  wire [79:0] resv_num    = 80'(pkts) * 80'(snap_pct);
  wire [79:0] op_num      = (calc_state == sppr_pkg::CALC_COUNT) ? count_num :
                            (calc_state == sppr_pkg::CALC_RATE) ? rate_num : resv_num;
  wire [79:0] op_den      = (calc_state == sppr_pkg::CALC_COUNT) ? 80'(data_of(snap_ps)) :
                            (calc_state == sppr_pkg::CALC_RATE) ? rate_den : `SPPR_PCT_FULL;
  wire [23:0] resv_q      = (div_q > 80'hffffff) ? 24'hffffff : div_q[23:0];

  // transmit decode
  wire        frame_go   = FRAME_START && (tx_state == sppr_pkg::TX_IDLE);
  wire        wait_over  = ns_acc >= wait_ns;
  wire [15:0] emit_bytes = (kind == sppr_pkg::SPPR_PAYLOAD) ?
                           ((rem > 32'(data_sz)) ? data_sz : rem[15:0]) : `SPPR_LT_PACKET_BYTES;
  wire [16:0] hold_bytes = 17'(emit_bytes) + ((kind == sppr_pkg::SPPR_TRAILER) ? 17'h0 : 17'(tx_gap));
  wire [32:0] pool_sum   = 33'(POOL_LEVEL) + 33'(RESERVE_LEFT);

  sppr_div #(.W(80)) u_div (
    .clk   (CLK),
    .rst   (RST),
    .start (div_start),
    .num   (op_num),
    .den   (op_den),
    .done  (div_done),
    .quo   (div_q)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg          <= {`SPPR_RST_PACKET_SIZE, `SPPR_RST_GAP, `SPPR_RST_DELAY, `SPPR_RST_PCT, `SPPR_RST_MULT};
      CHANNEL_ERR  <= 1'b0;
      PAYLOAD_SIZE <= 32'h0;
      TICK_FREQ    <= `SPPR_TICK_FREQ_HZ;
    end else begin
      if (cfg_ok) begin
        cfg <= {PACKET_SIZE, INTER_PACKET_GAP_TICKS, FRAME_DELAY_TICKS, RESERVE_PCT, ACCUM_MULT};
      end
      if (CFG_WRITE) begin
        CHANNEL_ERR <= !cfg_ok;
      end
      PAYLOAD_SIZE <= next_payload;
      TICK_FREQ    <= `SPPR_TICK_FREQ_HZ;
    end
  end

  // packet count, bandwidth and per-frame reserve, recomputed on any change
  always_ff @(posedge CLK) begin
    if (RST) begin
      calc_state        <= sppr_pkg::CALC_IDLE;
      snap              <= 80'h0;
      warm              <= 1'b0;
      launch            <= 1'b0;
      div_start         <= 1'b0;
      calc_done         <= 1'b0;
      pkts              <= 32'h1;
      BANDWIDTH         <= 32'h0;
      reserve_per_frame <= 24'h0;
      POOL_CAP          <= 32'h0;
    end else begin
      div_start <= 1'b0;
      calc_done <= 1'b0;
      warm      <= 1'b1; // payload register settled after reset
      case (calc_state)
        sppr_pkg::CALC_IDLE: begin
          if (warm && (calc_key != snap)) begin
            snap       <= calc_key;
            calc_state <= sppr_pkg::CALC_COUNT;
            launch     <= 1'b1;
          end
        end
        sppr_pkg::CALC_COUNT, sppr_pkg::CALC_RATE, sppr_pkg::CALC_RESV: begin
          if (launch) begin
            div_start <= 1'b1;
            launch    <= 1'b0;
          end else if (div_done) begin
            launch <= 1'b1;
            if (calc_state == sppr_pkg::CALC_COUNT) begin
              pkts       <= (div_q == 80'h0) ? 32'h1 : div_q[31:0];
              calc_state <= sppr_pkg::CALC_RATE;
            end else if (calc_state == sppr_pkg::CALC_RATE) begin
              BANDWIDTH  <= div_q[31:0];
              calc_state <= sppr_pkg::CALC_RESV;
            end else begin
              reserve_per_frame <= resv_q;
              POOL_CAP          <= 32'(resv_q) * 32'(snap_mult);
              calc_done         <= 1'b1;
              launch            <= 1'b0;
              calc_state        <= sppr_pkg::CALC_IDLE;
            end
          end
        end
        default: calc_state <= sppr_pkg::CALC_IDLE;
      endcase
    end
  end

  // resend reserve and accumulator pool
  always_comb begin
    next_res    = RESERVE_LEFT;
    next_pool   = (POOL_LEVEL > POOL_CAP) ? POOL_CAP : POOL_LEVEL;
    next_grant  = 1'b0;
    next_refuse = 1'b0;
    if (calc_done && !primed) begin
      next_pool = POOL_CAP;
    end
    if (FRAME_START) begin
      next_pool = (pool_sum > 33'(POOL_CAP)) ? POOL_CAP : pool_sum[31:0];
      next_res  = reserve_per_frame;
    end
    if (RESEND_REQ) begin
      if (next_res != 24'h0) begin
        next_res   = next_res - 24'h1;
        next_grant = 1'b1;
      end else if (next_pool != 32'h0) begin
        next_pool  = next_pool - 32'h1;
        next_grant = 1'b1;
      end else begin
        next_refuse = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      RESERVE_LEFT  <= 24'h0;
      POOL_LEVEL    <= 32'h0;
      primed        <= 1'b0;
      RESEND_GRANT  <= 1'b0;
      RESEND_REFUSE <= 1'b0;
    end else begin
      RESERVE_LEFT  <= next_res;
      POOL_LEVEL    <= next_pool;
      primed        <= primed | calc_done;
      RESEND_GRANT  <= next_grant;
      RESEND_REFUSE <= next_refuse;
    end
  end

  // block transmitter: delay, leader, payloads, trailer, each followed by its wire time
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_state  <= sppr_pkg::TX_IDLE;
      kind      <= sppr_pkg::SPPR_LEADER;
      ns_acc    <= 40'h0;
      wait_ns   <= 40'h0;
      rem       <= 32'h0;
      data_sz   <= 16'h1;
      tx_gap    <= 16'h0;
      last      <= 1'b0;
      PKT_START <= 1'b0;
      PKT_INFO  <= '0;
      TX_BUSY   <= 1'b0;
    end else begin
      PKT_START <= 1'b0;
      case (tx_state)
        sppr_pkg::TX_IDLE: begin
          if (frame_go) begin
            rem      <= PAYLOAD_SIZE;
            data_sz  <= data_of(cfg.packet_size);
            tx_gap   <= cfg.gap;
            wait_ns  <= to_ns(33'(cfg.delay));
            ns_acc   <= 40'h0;
            kind     <= sppr_pkg::SPPR_LEADER;
            last     <= 1'b0;
            TX_BUSY  <= 1'b1;
            tx_state <= sppr_pkg::TX_DELAY;
          end
        end
        sppr_pkg::TX_DELAY: begin
          if (wait_over) begin
            tx_state <= sppr_pkg::TX_EMIT;
          end else begin
            ns_acc <= ns_acc + `SPPR_CLK_PERIOD_NS;
          end
        end
        sppr_pkg::TX_EMIT: begin
          PKT_START <= 1'b1;
          PKT_INFO  <= {kind, emit_bytes};
          wait_ns   <= to_ns(33'(hold_bytes));
          ns_acc    <= 40'h0;
          tx_state  <= sppr_pkg::TX_HOLD;
          case (kind)
            sppr_pkg::SPPR_LEADER: kind <= sppr_pkg::SPPR_PAYLOAD;
            sppr_pkg::SPPR_PAYLOAD: begin
              rem <= rem - 32'(emit_bytes);
              if (rem == 32'(emit_bytes)) begin
                kind <= sppr_pkg::SPPR_TRAILER;
              end
            end
            default: last <= 1'b1;
          endcase
        end
        sppr_pkg::TX_HOLD: begin
          if (wait_over) begin
            tx_state <= last ? sppr_pkg::TX_IDLE : sppr_pkg::TX_EMIT;
            TX_BUSY  <= !last;
          end else begin
            ns_acc <= ns_acc + `SPPR_CLK_PERIOD_NS;
          end
        end
        default: tx_state <= sppr_pkg::TX_IDLE;
      endcase
    end
  end

  // checking helpers
  sppr_pkg::sppr_kind_t last_kind;
  logic [31:0] since_pkt;
  logic [31:0] since_go;
  logic [39:0] prev_hold;
  logic [39:0] go_ns;
  always_ff @(posedge CLK) begin
    if (RST) begin
      last_kind <= sppr_pkg::SPPR_TRAILER;
      since_pkt <= 32'h0;
      since_go  <= 32'h0;
      prev_hold <= 40'h0;
      go_ns     <= 40'h0;
    end else begin
      if (PKT_START) last_kind <= PKT_INFO.kind;
      since_pkt <= PKT_START ? 32'h1 : since_pkt + 32'h1;
      since_go  <= frame_go ? 32'h1 : since_go + 32'h1;
      if (tx_state == sppr_pkg::TX_EMIT) prev_hold <= wait_ns;
      if (frame_go) go_ns <= to_ns(33'(cfg.delay));
    end
  end

  sequence s_payload_pkt;
    PKT_START && (PKT_INFO.kind == sppr_pkg::SPPR_PAYLOAD);
  endsequence
  sequence s_leader_pkt;
    PKT_START && (PKT_INFO.kind == sppr_pkg::SPPR_LEADER);
  endsequence

  a_payload_sum: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> PAYLOAD_SIZE == $past(IMAGE_BYTES) + ($past(CHUNK_EN) ? $past(CHUNK_BYTES) : 32'h0))
    else $error("payload size mismatch");
  a_channel_guard: assert property (@(posedge CLK) disable iff (RST)
    CFG_WRITE && (CHANNEL_SEL != `SPPR_STREAM_CHANNEL) |=> $stable(cfg) && CHANNEL_ERR)
    else $error("setting taken on a foreign channel");
  a_block_order: assert property (@(posedge CLK) disable iff (RST)
    s_leader_pkt |-> last_kind == sppr_pkg::SPPR_TRAILER)
    else $error("leader before previous trailer");
  a_payload_after: assert property (@(posedge CLK) disable iff (RST)
    s_payload_pkt |-> last_kind != sppr_pkg::SPPR_TRAILER)
    else $error("payload outside a block");
  a_header_size: assert property (@(posedge CLK) disable iff (RST)
    PKT_START && (PKT_INFO.kind != sppr_pkg::SPPR_PAYLOAD) |-> PKT_INFO.bytes == `SPPR_LT_PACKET_BYTES)
    else $error("leader or trailer size wrong");
  a_payload_len: assert property (@(posedge CLK) disable iff (RST)
    s_payload_pkt ##1 (!PKT_START)[*1] ##0 (kind == sppr_pkg::SPPR_PAYLOAD)
    |-> $past(PKT_INFO.bytes, 1) == data_sz)
    else $error("non-final payload not full");
  a_gap_length: assert property (@(posedge CLK) disable iff (RST)
    PKT_START && (PKT_INFO.kind != sppr_pkg::SPPR_LEADER) |->
      (40'(since_pkt) * `SPPR_CLK_PERIOD_NS >= prev_hold + 40'h32) &&
      (40'(since_pkt) * `SPPR_CLK_PERIOD_NS < prev_hold + 40'h4b))
    else $error("inter-packet spacing wrong");
  a_tick_freq: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> TICK_FREQ == `SPPR_TICK_FREQ_HZ)
    else $error("tick frequency wrong");
  a_start_delay: assert property (@(posedge CLK) disable iff (RST)
    s_leader_pkt |-> (40'(since_go) * `SPPR_CLK_PERIOD_NS >= go_ns + 40'h4b) &&
      (40'(since_go) * `SPPR_CLK_PERIOD_NS < go_ns + 40'h64))
    else $error("frame start delay wrong");
  a_pool_capped: assert property (@(posedge CLK) disable iff (RST)
    FRAME_START ##1 $stable(POOL_CAP) |-> POOL_LEVEL <= POOL_CAP)
    else $error("pool above cap");
  a_pool_debit: assert property (@(posedge CLK) disable iff (RST)
    RESEND_REQ && !FRAME_START && (RESERVE_LEFT == 24'h0) && (POOL_LEVEL != 32'h0) &&
      (POOL_LEVEL <= POOL_CAP) && !calc_done |=> RESEND_GRANT && (POOL_LEVEL == $past(POOL_LEVEL) - 32'h1))
    else $error("pool not debited");
  a_refuse_empty: assert property (@(posedge CLK) disable iff (RST)
    RESEND_REQ && !FRAME_START && !calc_done && (RESERVE_LEFT == 24'h0) && (POOL_LEVEL == 32'h0)
      |=> RESEND_REFUSE && !RESEND_GRANT)
    else $error("empty pool did not refuse");
  a_reserve_reload: assert property (@(posedge CLK) disable iff (RST)
    FRAME_START && !RESEND_REQ |=> RESERVE_LEFT == $past(reserve_per_frame))
    else $error("reserve not reloaded");
endmodule

// ==== dv/sppr_host_model.sv ====
// host receive model: checks block framing and pacing, issues resends
// assumes packet outputs and resend answers change on posedge clk
`timescale 1ns/1ps
module sppr_host_model (
  input  wire logic                clk,
  input  wire logic                pkt_start,
  input  wire sppr_pkg::sppr_pkt_t pkt_info,
  input  wire logic [15:0]         gap,
  input  wire logic                grant,
  input  wire logic                refuse,
  output logic                     resend_req,
  output int                       n_payload,
  output int                       pay_bytes,
  output int                       first_bytes,
  output int                       bad,
  output int                       grants,
  output int                       refusals
);
  sppr_pkg::sppr_kind_t last_kind;
  int                   since;
  int                   need;
  logic                 order_bad;
  logic                 space_bad;
  logic                 size_bad;
  // leader after trailer, payload never after trailer, trailer only after payload
  assign order_bad = (pkt_info.kind == sppr_pkg::SPPR_LEADER) ? (last_kind != sppr_pkg::SPPR_TRAILER) :
                     (pkt_info.kind == sppr_pkg::SPPR_PAYLOAD) ? (last_kind == sppr_pkg::SPPR_TRAILER) :
                     (last_kind != sppr_pkg::SPPR_PAYLOAD);
  assign space_bad = (last_kind != sppr_pkg::SPPR_TRAILER) && (since != need);
  assign size_bad  = (pkt_info.kind != sppr_pkg::SPPR_PAYLOAD) && (pkt_info.bytes != 16'h0012);
  task automatic clear();
    resend_req  = 1'b0;
    n_payload   = 0;
    pay_bytes   = 0;
    first_bytes = 0;
    last_kind   = sppr_pkg::SPPR_TRAILER;
  endtask
  // back-to-back requests, one per cycle
  task automatic request(input int k);
    repeat (k) begin
      @(negedge clk);
      resend_req = 1'b1;
    end
    @(negedge clk);
    resend_req = 1'b0;
  endtask
  initial begin
    clear();
    bad      = 0;
    grants   = 0;
    refusals = 0;
    since    = 0;
    need     = 0;
  end
  always @(posedge clk) begin
    since <= since + 1;
    if (grant)
      grants <= grants + 1;
    if (refuse)
      refusals <= refusals + 1;
    if (pkt_start) begin
      since     <= 1;
      need      <= 2 + ((int'(pkt_info.bytes) + int'(gap)) * 8 + 24) / 25;
      last_kind <= pkt_info.kind;
      bad       <= bad + int'(order_bad) + int'(space_bad) + int'(size_bad);
      if (pkt_info.kind == sppr_pkg::SPPR_PAYLOAD) begin
        pay_bytes <= pay_bytes + int'(pkt_info.bytes);
        n_payload <= n_payload + 1;
        if (n_payload == 0)
          first_bytes <= int'(pkt_info.bytes);
      end
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the stream packet pacer and resend pool
// assumes sppr_pkg and the design compiled first, host model beside it
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [15:0] size;
    logic [15:0] gap;
    logic [31:0] delay;
    logic [7:0]  pct;
    logic [7:0]  mult;
    logic [31:0] img;
    logic [31:0] chk;
    logic        en;
    logic [31:0] pay;
    logic [31:0] npay;
    logic [31:0] first;
    logic [31:0] lead;
    logic [31:0] cap;
    logic [31:0] bw;
  } sppr_row_t;
  logic                CLK, RST, CFG_WRITE, CHUNK_EN, FRAME_START, RESEND_REQ;
  logic [7:0]          CHANNEL_SEL, RESERVE_PCT, ACCUM_MULT;
  logic [15:0]         PACKET_SIZE, INTER_PACKET_GAP_TICKS;
  logic [31:0]         FRAME_DELAY_TICKS, IMAGE_BYTES, CHUNK_BYTES;
  logic                PKT_START, TX_BUSY, CHANNEL_ERR, RESEND_GRANT, RESEND_REFUSE;
  sppr_pkg::sppr_pkt_t PKT_INFO;
  logic [31:0]         PAYLOAD_SIZE, TICK_FREQ, BANDWIDTH, POOL_LEVEL, POOL_CAP;
  logic [23:0]         RESERVE_LEFT;
  sppr_row_t           rows [3];
  sppr_row_t           bad_row;
  int                  mismatches, compares, cycles, lat, pool_m, left_m, nref, g0, r0;
  int                  need [7] = '{0, 7, 4, 10, 20, 1, 0};
  sppr_top dut (.CLK(CLK), .RST(RST), .CFG_WRITE(CFG_WRITE), .CHANNEL_SEL(CHANNEL_SEL),
    .PACKET_SIZE(PACKET_SIZE), .INTER_PACKET_GAP_TICKS(INTER_PACKET_GAP_TICKS),
    .FRAME_DELAY_TICKS(FRAME_DELAY_TICKS), .RESERVE_PCT(RESERVE_PCT), .ACCUM_MULT(ACCUM_MULT),
    .IMAGE_BYTES(IMAGE_BYTES), .CHUNK_BYTES(CHUNK_BYTES), .CHUNK_EN(CHUNK_EN), .FRAME_START(FRAME_START),
    .RESEND_REQ(RESEND_REQ), .PKT_START(PKT_START), .PKT_INFO(PKT_INFO), .TX_BUSY(TX_BUSY),
    .CHANNEL_ERR(CHANNEL_ERR), .PAYLOAD_SIZE(PAYLOAD_SIZE), .TICK_FREQ(TICK_FREQ), .BANDWIDTH(BANDWIDTH),
    .RESERVE_LEFT(RESERVE_LEFT), .POOL_LEVEL(POOL_LEVEL), .POOL_CAP(POOL_CAP),
    .RESEND_GRANT(RESEND_GRANT), .RESEND_REFUSE(RESEND_REFUSE));
  sppr_host_model host (.clk(CLK), .pkt_start(PKT_START), .pkt_info(PKT_INFO), .gap(INTER_PACKET_GAP_TICKS),
    .grant(RESEND_GRANT), .refuse(RESEND_REFUSE), .resend_req(RESEND_REQ), .n_payload(), .pay_bytes(),
    .first_bytes(), .bad(), .grants(), .refusals());
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    @(negedge CLK);
    RST = 1'b1;
    repeat (6) @(negedge CLK);
    RST = 1'b0;
  endtask
  task automatic cfg(input logic [7:0] ch, input sppr_row_t r);
    @(negedge CLK);
    CHANNEL_SEL            = ch;
    PACKET_SIZE            = r.size;
    INTER_PACKET_GAP_TICKS = r.gap;
    FRAME_DELAY_TICKS      = r.delay;
    RESERVE_PCT            = r.pct;
    ACCUM_MULT             = r.mult;
    IMAGE_BYTES            = r.img;
    CHUNK_BYTES            = r.chk;
    CHUNK_EN               = r.en;
    CFG_WRITE              = 1'b1;
    @(negedge CLK);
    CFG_WRITE = 1'b0;
    repeat (300) @(negedge CLK);
  endtask
  task automatic frame();
    @(negedge CLK);
    FRAME_START = 1'b1;
    @(negedge CLK);
    FRAME_START = 1'b0;
  endtask
  initial begin
    rows[0] = '{16'h05dc, 16'h0000, 32'h0, 8'h64, 8'h03, 32'h0bb8, 32'h0064, 1'b1,
                32'h0c1c, 32'h3, 32'h05b8, 32'h2, 32'h9, 32'h07735940};
    rows[1] = '{16'h0064, 16'h000a, 32'h64, 8'h32, 8'h02, 32'h0080, 32'h0032, 1'b0,
                32'h0080, 32'h2, 32'h0040, 32'h22, 32'h2, 32'h071885c3};
    rows[2] = '{16'h0240, 16'h0003, 32'h7, 8'h64, 8'h01, 32'h01f4, 32'h0028, 1'b1,
                32'h021c, 32'h1, 32'h021c, 32'h5, 32'h1, 32'h07735940};
    {CFG_WRITE, FRAME_START, CHANNEL_SEL, RESERVE_PCT, ACCUM_MULT} = '0;
    {PACKET_SIZE, INTER_PACKET_GAP_TICKS, FRAME_DELAY_TICKS, CHUNK_BYTES, CHUNK_EN} = '0;
    IMAGE_BYTES = 32'h00011df0;
    RST         = 1'b1;
    {mismatches, compares, cycles} = '0;
    do_reset();
    chk(TICK_FREQ, 32'h07735940);
    repeat (300) @(negedge CLK);
    chk(POOL_CAP, 32'h0000000a);
    chk(POOL_LEVEL, 32'h0000000a);
    chk(PAYLOAD_SIZE, 32'h00011df0);
    chk(BANDWIDTH, 32'h07735940);
    // default config, zero frame delay; seven frame periods of resends
    pool_m = 10;
    left_m = 0;
    for (int p = 0; p < 7; p++) begin
      frame();
      pool_m = (pool_m + left_m > 10) ? 10 : pool_m + left_m;
      left_m = 5;
      chk({8'h00, RESERVE_LEFT}, left_m);
      chk(POOL_LEVEL, pool_m);
      g0   = host.grants;
      r0   = host.refusals;
      nref = 0;
      host.request(need[p]);
      for (int k = 0; k < need[p]; k++) begin
        if (left_m > 0)
          left_m--;
        else if (pool_m > 0)
          pool_m--;
        else
          nref++;
      end
      repeat (2) @(negedge CLK);
      chk(host.refusals - r0, nref);
      chk(host.grants - g0, need[p] - nref);
    end
    while (TX_BUSY !== 1'b0) @(negedge CLK);
    chk(host.n_payload, 32'h32);
    chk(host.pay_bytes, 32'h00011df0);
    foreach (rows[i]) begin
      cfg(8'h00, rows[i]);
      chk(PAYLOAD_SIZE, rows[i].pay);
      chk(BANDWIDTH, rows[i].bw);
      chk(POOL_CAP, rows[i].cap);
      host.clear();
      frame();
      chk({31'h0, TX_BUSY}, 32'h1);
      lat = 0;
      while (PKT_START !== 1'b1 && lat < 2000) begin
        @(negedge CLK);
        lat++;
      end
      chk(lat, rows[i].lead);
      while (TX_BUSY !== 1'b0) @(negedge CLK);
      chk(host.n_payload, rows[i].npay);
      chk(host.first_bytes, rows[i].first);
      chk(host.pay_bytes, rows[i].pay);
    end
    // write to channel one must leave settings untouched
    bad_row      = rows[2];
    bad_row.mult = 8'h05;
    cfg(8'h01, bad_row);
    chk({31'h0, CHANNEL_ERR}, 32'h1);
    chk(POOL_CAP, rows[2].cap);
    cfg(8'h00, rows[2]);
    chk({31'h0, CHANNEL_ERR}, 32'h0);
    chk(host.bad, 32'h0);
    // mid-run reset reloads a full pool
    IMAGE_BYTES = 32'h00011df0;
    CHUNK_EN    = 1'b0;
    do_reset();
    chk(POOL_LEVEL, 32'h0);
    repeat (300) @(negedge CLK);
    chk(POOL_LEVEL, 32'h0000000a);
    chk(POOL_CAP, 32'h0000000a);
    conclude();
  end
endmodule
